// [src/asg_pkg.sv]
// shared constants for the adjustable square wave generator
package asg_pkg;

   // ----------------------------------------------------------------
   // clock rates and the crystal oscillator model
   // ----------------------------------------------------------------
   localparam int ASG_PCLK_KHZ = 40000;
   localparam int ASG_OSC_KHZ = 5760;
   localparam int ASG_COUNT_KHZ = 720;
   localparam int ASG_ACC_W = 16;
   localparam logic [ASG_ACC_W-1:0] ASG_ACC_STEP = ASG_OSC_KHZ[ASG_ACC_W-1:0];
   localparam logic [ASG_ACC_W-1:0] ASG_ACC_WRAP = ASG_PCLK_KHZ[ASG_ACC_W-1:0];
   localparam int ASG_DIV_STAGES = 3;

   // ----------------------------------------------------------------
   // counter geometry and preset patterns, one per frequency strap
   // ----------------------------------------------------------------
   localparam int ASG_STAGES = 17;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_200 = 17'h1f8f8;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_360 = 17'h1fc18;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_500 = 17'h1fd30;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_720 = 17'h1fe0c;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_1000 = 17'h1fe98;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_1200 = 17'h1fed4;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_2000 = 17'h1ff4c;
   localparam logic [ASG_STAGES-1:0] ASG_PRESET_AUX = 17'h1fe70;

   // ----------------------------------------------------------------
   // register map (byte addresses) and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] ASG_CTRL_ADDR = 8'h00;
   localparam logic [7:0] ASG_CMD_ADDR = 8'h04;
   localparam logic [7:0] ASG_STATUS_ADDR = 8'h08;
   localparam logic [7:0] ASG_COUNT_ADDR = 8'h0c;
   localparam int ASG_CTRL_SEL_LSB = 0;
   localparam int ASG_CTRL_CONT_BIT = 3;
   localparam int ASG_CMD_START_BIT = 0;
   localparam int ASG_CMD_STOP_BIT = 1;
   localparam int ASG_ST_HALT_BIT = 0;
   localparam int ASG_ST_OVF_BIT = 1;
   localparam int ASG_ST_OUT_BIT = 2;
   localparam int ASG_ST_LOAD_BIT = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] ASG_SEL_RESET = 3'h0;
   localparam logic ASG_CONT_RESET = 1'b0;
   localparam logic ASG_HALT_RESET = 1'b1;

   // frequency strap positions J1..J8
   typedef enum logic [2:0] {
      ASG_SEL_200, ASG_SEL_360, ASG_SEL_500, ASG_SEL_720,
      ASG_SEL_1000, ASG_SEL_1200, ASG_SEL_2000, ASG_SEL_AUX
   } asg_sel_type;

endpackage

// [src/asg_square_wave_gen.sv]
// adjustable square wave generator with apb register access
`timescale 1ns/100ps

module asg_square_wave_gen
   import asg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic init_switch,
   output logic pulse_out,
   output logic halt_flag,
   output logic overflow_flag
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [ASG_ACC_W-1:0] osc_acc_q;
   logic osc_tick;
   logic [ASG_DIV_STAGES-1:0] oscillator_divider_stage_q;
   logic count_tick;
   logic count_clock_gate;
   logic count_en;
   logic [2:0] freq_sel_q;
   logic run_continuous_q;
   logic halt_flag_q;
   logic overflow_flag_q;
   logic output_toggle_ff_q;
   logic [ASG_STAGES-1:0] stage_q;
   logic [ASG_STAGES-1:0] stage_inc;
   logic [ASG_STAGES-1:0] preset_pattern;
   logic preset_load_enable;
   logic start_generator_command;
   logic stop_generator_command;
   logic restart_event;
   logic wr_access;
   logic rd_setup;
   logic addr_mapped;
   logic [31:0] prdata_q;
   logic [31:0] read_mux;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_access = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign addr_mapped = (paddr == ASG_CTRL_ADDR) || (paddr == ASG_CMD_ADDR) ||
                        (paddr == ASG_STATUS_ADDR) || (paddr == ASG_COUNT_ADDR);
   assign pslverr = psel & penable & ~addr_mapped;
   assign prdata = prdata_q;

   // command writes act as one-cycle strobes, nothing is stored
   assign start_generator_command = wr_access && (paddr == ASG_CMD_ADDR) && pwdata[ASG_CMD_START_BIT];
   assign stop_generator_command = wr_access && (paddr == ASG_CMD_ADDR) && pwdata[ASG_CMD_STOP_BIT];

   // ----------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_sel_q <= ASG_SEL_RESET;
         run_continuous_q <= ASG_CONT_RESET;
      end else if (wr_access && (paddr == ASG_CTRL_ADDR)) begin
         freq_sel_q <= pwdata[ASG_CTRL_SEL_LSB +: 3];
         run_continuous_q <= pwdata[ASG_CTRL_CONT_BIT];
      end
   end

   // ----------------------------------------------------------------
   // read data, captured in the setup cycle so it comes from a flop
   // ----------------------------------------------------------------
   always_comb begin
      read_mux = 32'h0000_0000;
      case (paddr)
         ASG_CTRL_ADDR: begin
            read_mux[ASG_CTRL_SEL_LSB +: 3] = freq_sel_q;
            read_mux[ASG_CTRL_CONT_BIT] = run_continuous_q;
         end
         ASG_STATUS_ADDR: begin
            read_mux[ASG_ST_HALT_BIT] = halt_flag_q;
            read_mux[ASG_ST_OVF_BIT] = overflow_flag_q;
            read_mux[ASG_ST_OUT_BIT] = output_toggle_ff_q;
            read_mux[ASG_ST_LOAD_BIT] = preset_load_enable;
         end
         ASG_COUNT_ADDR: begin
            read_mux[ASG_STAGES-1:0] = stage_q;
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_q <= read_mux;
      end
   end

   // ----------------------------------------------------------------
   // crystal oscillator and divide-by-eight
   // ----------------------------------------------------------------
   // the crystal is modelled by a phase accumulator: exact on average,
   // with one pclk of jitter on each oscillator edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_acc_q <= '0;
      end else if (osc_acc_q + ASG_ACC_STEP >= ASG_ACC_WRAP) begin
         osc_acc_q <= ASG_ACC_W'(osc_acc_q + ASG_ACC_STEP - ASG_ACC_WRAP);
      end else begin
         osc_acc_q <= ASG_ACC_W'(osc_acc_q + ASG_ACC_STEP);
      end
   end

   assign osc_tick = (osc_acc_q + ASG_ACC_STEP >= ASG_ACC_WRAP);

   // three cascaded halvers; the oscillator free-runs and is never gated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oscillator_divider_stage_q <= '0;
      end else if (osc_tick) begin
         oscillator_divider_stage_q <= ASG_DIV_STAGES'(oscillator_divider_stage_q + 1'b1);
      end
   end

   // one count clock each time the last halver falls
   assign count_tick = osc_tick && (&oscillator_divider_stage_q);

   // ----------------------------------------------------------------
   // halt flag and clock gate
   // ----------------------------------------------------------------
   assign restart_event = start_generator_command | init_switch | run_continuous_q;

   // restart wins over a stop in the same cycle: the continuous strap must
   // never be overridden by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_flag_q <= ASG_HALT_RESET;
      end else if (restart_event) begin
         halt_flag_q <= 1'b0;
      end else if (stop_generator_command) begin
         halt_flag_q <= 1'b1;
      end
   end

   assign count_clock_gate = ~(halt_flag_q & ~run_continuous_q);
   assign count_en = count_tick & count_clock_gate;

   // ----------------------------------------------------------------
   // preset selection
   // ----------------------------------------------------------------
   always_comb begin
      preset_pattern = '0;
      case (asg_sel_type'(freq_sel_q))
         ASG_SEL_200: preset_pattern = ASG_PRESET_200;
         ASG_SEL_360: preset_pattern = ASG_PRESET_360;
         ASG_SEL_500: preset_pattern = ASG_PRESET_500;
         ASG_SEL_720: preset_pattern = ASG_PRESET_720;
         ASG_SEL_1000: preset_pattern = ASG_PRESET_1000;
         ASG_SEL_1200: preset_pattern = ASG_PRESET_1200;
         ASG_SEL_2000: preset_pattern = ASG_PRESET_2000;
         ASG_SEL_AUX: preset_pattern = ASG_PRESET_AUX;
         default: preset_pattern = ASG_PRESET_200;
      endcase
   end

   assign preset_load_enable = ~halt_flag_q & ~overflow_flag_q;
   assign stage_inc = ASG_STAGES'(stage_q + 1'b1);

   // ----------------------------------------------------------------
   // seventeen-stage counter
   // ----------------------------------------------------------------
   // while the preset is held, stages 16..02 are forced and only 01..00
   // count; no pattern uses stages 01 or 00, so two clocks reach stage 01
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_q <= '0;
      end else if (stop_generator_command && !restart_event) begin
         stage_q <= '0;
      end else if (preset_load_enable) begin
         stage_q[ASG_STAGES-1:2] <= preset_pattern[ASG_STAGES-1:2];
         if (count_en) begin
            stage_q[1:0] <= 2'(stage_q[1:0] + 1'b1);
         end
      end else if (count_en) begin
         stage_q <= stage_inc;
      end
   end

   // ----------------------------------------------------------------
   // overflow flag and output toggle
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_q <= 1'b0;
      end else if (stop_generator_command && !restart_event) begin
         overflow_flag_q <= 1'b0;
      end else if (count_en && preset_load_enable && stage_q[1:0] == 2'h1) begin
         overflow_flag_q <= 1'b1;
      end else if (count_en && overflow_flag_q && stage_q[ASG_STAGES-1] && !stage_inc[ASG_STAGES-1]) begin
         overflow_flag_q <= 1'b0;
      end
   end

   // each half period is 2^17 minus the preset count clocks long,
   // identical for both phases
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_toggle_ff_q <= 1'b0;
      end else if (count_en && overflow_flag_q && stage_q[ASG_STAGES-1] && !stage_inc[ASG_STAGES-1]) begin
         output_toggle_ff_q <= ~output_toggle_ff_q;
      end
   end

   assign pulse_out = output_toggle_ff_q;
   assign halt_flag = halt_flag_q;
   assign overflow_flag = overflow_flag_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_count_rate_div: assert property (count_tick |=> !count_tick [*8])
      else $error("count clock faster than oscillator over eight");

   a_osc_before_tick: assert property (count_tick |-> osc_tick && oscillator_divider_stage_q == 3'h7)
      else $error("count clock without full divider wrap");

   a_stop_sets_halt: assert property (stop_generator_command && !restart_event |=> halt_flag_q && stage_q == '0
                                      && !overflow_flag_q)
      else $error("stop did not halt and clear the counter");

   a_halt_blocks_clk: assert property (halt_flag_q && !run_continuous_q |-> !count_en ##1 $stable(stage_q[1:0]))
      else $error("count clock passed while halted");

   a_restart_clears: assert property (restart_event |=> !halt_flag_q)
      else $error("restart event left halt set");

   a_preset_loaded: assert property (preset_load_enable && !stop_generator_command
                                     |=> stage_q[16:2] == $past(preset_pattern[16:2]))
      else $error("preset not forced into stages");

   a_ovf_on_stage1: assert property ($rose(overflow_flag_q) |-> stage_q[1:0] == 2'h2
                                     && stage_q[16:2] == preset_pattern[16:2])
      else $error("overflow set away from stage one");

   a_top_fall_toggle: assert property ($fell(overflow_flag_q) && !$past(stop_generator_command)
                                       |-> pulse_out != $past(pulse_out) && stage_q == '0)
      else $error("overflow clear without output toggle");

   a_toggle_needs_ovf: assert property ($changed(pulse_out) |-> $fell(overflow_flag_q))
      else $error("output changed outside an overflow clear");

   a_halted_frozen: assert property (halt_flag_q && !restart_event ##1 halt_flag_q |-> $stable(stage_q))
      else $error("counter moved while halted");

   a_div_hold: assert property (!osc_tick |=> $stable(oscillator_divider_stage_q))
      else $error("divider moved without an oscillator edge");

   a_div_change: assert property (osc_tick |=> $changed(oscillator_divider_stage_q))
      else $error("divider ignored an oscillator edge");

   a_cont_clears_halt: assert property (run_continuous_q |=> !halt_flag_q)
      else $error("continuous strap left halt set");

   a_init_clears_halt: assert property (init_switch |=> !halt_flag_q)
      else $error("initialise switch left halt set");

   a_cont_gate_open: assert property (run_continuous_q |-> count_clock_gate)
      else $error("count clock gated in continuous mode");

   a_load_needs_clear: assert property (preset_load_enable |-> !halt_flag_q && !overflow_flag_q)
      else $error("preset forced while halt or overflow set");

   a_count_step: assert property (count_en && !preset_load_enable && !stop_generator_command
                                  |=> stage_q == $past(stage_inc))
      else $error("counter did not step on a count clock");

   a_count_idle: assert property (!count_en && !preset_load_enable && !stop_generator_command
                                  |=> $stable(stage_q))
      else $error("counter moved without a count clock");

   a_ovf_steady: assert property (!count_en && !stop_generator_command |=> $stable(overflow_flag_q))
      else $error("overflow flag moved without a count clock");

   a_out_steady: assert property (!count_en |=> $stable(pulse_out))
      else $error("output moved without a count clock");

   a_stop_freezes_out: assert property (halt_flag_q && !run_continuous_q |=> $stable(pulse_out))
      else $error("output moved while halted");

   a_ovf_top_set: assert property (overflow_flag_q |-> stage_q[ASG_STAGES-1])
      else $error("overflow set with the top stage clear");

   a_wrap_at_top: assert property (count_en && overflow_flag_q && (&stage_q)
                                   |=> !overflow_flag_q && stage_q == '0)
      else $error("counter wrap did not clear overflow");

   a_reload_after_wrap: assert property ($fell(overflow_flag_q) && !halt_flag_q && !stop_generator_command
                                         |=> stage_q[16:2] == $past(preset_pattern[16:2]))
      else $error("preset not reloaded after overflow clear");

   a_ovf_from_load: assert property ($rose(overflow_flag_q) |-> $past(preset_load_enable) && $past(count_en))
      else $error("overflow set outside a preset count");

   c_output_toggles: cover property ($rose(pulse_out));
   c_stop_then_start: cover property ($rose(halt_flag_q) ##[1:20] $fell(halt_flag_q));
   c_continuous_run: cover property (run_continuous_q && $fell(overflow_flag_q));
   c_init_restart: cover property (halt_flag_q && init_switch ##1 !halt_flag_q);
   c_reload_after_wrap: cover property ($fell(overflow_flag_q) ##1 preset_load_enable);

endmodule // asg_square_wave_gen

// [bench/asg_pulse_monitor.sv]
// far-side model: pulse receiver that measures half periods
`timescale 1ns/100ps

module asg_pulse_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pulse_in,
   output int n_edges,
   output int high_len,
   output int low_len
);
   // ----------------------------------------------------------------
   // edge timing, in pclk cycles between detected edges
   // ----------------------------------------------------------------
   // acts as a high-resolution clock input, so the bench runs program-controlled
   // the source-select strap upstream is taken as routing this generator, not line frequency
   logic last_q;
   int cyc_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 1'b0;
         cyc_q <= 0;
         n_edges <= 0;
         high_len <= 0;
         low_len <= 0;
      end else if (pulse_in !== last_q) begin
         last_q <= pulse_in;
         n_edges <= n_edges + 1;
         cyc_q <= 1;
         if (last_q) begin
            high_len <= cyc_q;
         end else begin
            low_len <= cyc_q;
         end
      end else begin
         cyc_q <= cyc_q + 1;
      end
   end
endmodule // asg_pulse_monitor

// [bench/tb_top.sv]
// self-checking bench for the adjustable square wave generator
`timescale 1ns/100ps

module tb_top
   import asg_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic pclk;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic init_switch = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pulse_out;
   logic halt_flag;
   logic overflow_flag;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int mon_edges;
   int mon_high;
   int mon_low;
   // expected preset patterns, built from the stage lists of each strap
   logic [16:0] exp_preset [8] = '{17'h1f8f8, 17'h1fc18, 17'h1fd30, 17'h1fe0c,
      17'h1fe98, 17'h1fed4, 17'h1ff4c, 17'h1fe70};

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   asg_square_wave_gen i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .init_switch(init_switch), .pulse_out(pulse_out),
      .halt_flag(halt_flag), .overflow_flag(overflow_flag));

   asg_pulse_monitor i_mon (.pclk(pclk), .presetn(presetn), .pulse_in(pulse_out),
      .n_edges(mon_edges), .high_len(mon_high), .low_len(mon_low));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // oscillator jitter moves each edge by at most a pclk, so a few cycles of slack
   task automatic check_near(input string what, input int got, input int exp);
      n_compared++;
      if (got > exp + 4 || got < exp - 4) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] data, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: a slave that never answers is caught by the bench timeout
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      data = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
      logic [31:0] d;
      logic e;
      apb(1'b1, addr, wdata, d, e);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, addr, 32'h0, d, e);
      check("read", d, exp);
   endtask

   // let the command edge and the flag update land before sampling
   task automatic settle();
      repeat (2) @(posedge pclk);
   endtask

   task automatic wait_edges(input int n, input int limit);
      int target;
      int i;
      target = mon_edges + n;
      for (i = 0; i < limit && mon_edges < target; i++) begin
         @(posedge pclk);
      end
      check("edges", mon_edges, target);
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         $display("BAD %0t timeout got %h exp %h", $time, cycles, 0);
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic e;
      int i;
      int ev;
      logic p;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      check("halt rst", halt_flag, 1'b1);
      check("out rst", pulse_out, 1'b0);
      check("pready", pready, 1'b1);
      rd_chk(ASG_CTRL_ADDR, 32'h0);
      rd_chk(ASG_STATUS_ADDR, 32'h1);
      rd_chk(ASG_COUNT_ADDR, 32'h0);
      rd_chk(ASG_CMD_ADDR, 32'h0);
      apb(1'b0, 8'h10, 32'h0, d, e);
      check("unmapped err", e, 1'b1);
      check("unmapped data", d, 32'h0);
      $display("test reset done");

      for (i = 0; i < 8; i++) begin
         wr(ASG_CTRL_ADDR, i);
         wr(ASG_CMD_ADDR, 32'h1);
         apb(1'b0, ASG_COUNT_ADDR, 32'h0, d, e);
         check("preset", d[16:2], exp_preset[i][16:2]);
         wr(ASG_CMD_ADDR, 32'h2);
         rd_chk(ASG_COUNT_ADDR, 32'h0);
         rd_chk(ASG_STATUS_ADDR, 32'h1);
      end
      $display("test presets done");

      wr(ASG_CTRL_ADDR, 32'h6);
      wr(ASG_CMD_ADDR, 32'h1);
      for (i = 0; i < 200 && overflow_flag !== 1'b1; i++) begin
         @(posedge pclk);
      end
      check("ovf set", overflow_flag, 1'b1);
      check("halt off", halt_flag, 1'b0);
      wait_edges(1, 12000);
      check("out high", pulse_out, 1'b1);
      wait_edges(2, 25000);
      check_near("high", mon_high, 180 * ASG_PCLK_KHZ / ASG_COUNT_KHZ);
      check_near("low", mon_low, 180 * ASG_PCLK_KHZ / ASG_COUNT_KHZ);
      wr(ASG_CMD_ADDR, 32'h2);
      settle();
      p = pulse_out;
      ev = mon_edges;
      repeat (600) @(posedge pclk);
      check("frozen edges", mon_edges, ev);
      check("frozen out", pulse_out, p);
      rd_chk(ASG_COUNT_ADDR, 32'h0);
      $display("test rate 2000 done");

      wr(ASG_CTRL_ADDR, 32'h5);
      wr(ASG_CMD_ADDR, 32'h1);
      wait_edges(2, 40000);
      // the falling edge closes a half that spans the stop, so only the low half is clean
      check_near("half", mon_low, ASG_PCLK_KHZ * 1000 / (2 * 1200));
      wr(ASG_CMD_ADDR, 32'h2);
      $display("test rate 1200 done");

      // the continuous strap and the initialise switch must both override a stop
      wr(ASG_CTRL_ADDR, 32'hd);
      settle();
      check("cont run", halt_flag, 1'b0);
      wr(ASG_CMD_ADDR, 32'h2);
      settle();
      check("cont stop", halt_flag, 1'b0);
      wr(ASG_CTRL_ADDR, 32'h5);
      wr(ASG_CMD_ADDR, 32'h2);
      settle();
      check("prog stop", halt_flag, 1'b1);
      init_switch <= 1'b1;
      settle();
      check("init run", halt_flag, 1'b0);
      wr(ASG_CMD_ADDR, 32'h2);
      settle();
      check("init stop", halt_flag, 1'b0);
      init_switch <= 1'b0;
      wr(ASG_CMD_ADDR, 32'h2);
      settle();
      check("stop again", halt_flag, 1'b1);
      wr(ASG_CMD_ADDR, 32'h3);
      settle();
      check("start wins", halt_flag, 1'b0);
      wr(ASG_CMD_ADDR, 32'h2);
      $display("test restart events done");
      report_and_stop();
   end
endmodule // tb_top
